// ===== hdl/tsc_pkg.sv
// tsc_pkg: shared constants and types of the temperature trip comparator
package tsc_pkg;

	// ************************************************************
	// register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [5:0] IDX_CONFIG = 6'h01;
	localparam logic [5:0] IDX_UPPER  = 6'h02;
	localparam logic [5:0] IDX_LOWER  = 6'h03;
	localparam logic [5:0] IDX_CRIT   = 6'h04;
	localparam logic [5:0] IDX_TEMP   = 6'h05;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int TRIP_MSB   = 12;
	localparam int TRIP_LSB   = 2;
	localparam int TRIP_W     = TRIP_MSB - TRIP_LSB + 1;
	localparam int TEMP_W     = 13;
	localparam int FLAG_BELOW = 13;
	localparam int FLAG_ABOVE = 14;
	localparam int FLAG_CRIT  = 15;
	localparam int HYST_LSB   = 9;
	localparam int HYST_MSB   = 10;

	// ************************************************************
	// values after reset
	// ************************************************************
	localparam logic [10:0] TRIP_RESET = 11'h000;
	localparam logic [12:0] TEMP_RESET = 13'h0000;
	localparam logic [1:0]  HYST_RESET = 2'h0;

	// ************************************************************
	// hysteresis widths in reading steps of 1/16 degree
	// ************************************************************
	localparam logic [13:0] HYST_DLT_OFF = 14'h0000;
	localparam logic [13:0] HYST_DLT_1P5 = 14'h0018;
	localparam logic [13:0] HYST_DLT_3   = 14'h0030;
	localparam logic [13:0] HYST_DLT_6   = 14'h0060;

	typedef enum logic [1:0] {
		TSC_HYST_OFF,
		TSC_HYST_1P5,
		TSC_HYST_3,
		TSC_HYST_6
	} tsc_hyst_t;

	// ************************************************************
	// ahb-lite
	// ************************************************************
	localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage

// ===== hdl/tsc_trip_reg.sv
// tsc_trip_reg: one trip-point register with its reserved bits masked
`timescale 1ns/1ns
`default_nettype none

module tsc_trip_reg
	import tsc_pkg::*;
(
	// clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// write side
	input  wire logic               wr_en,
	input  wire logic [15:0]        wr_data,
	// stored value and its read image
	output logic      [TRIP_W-1:0]  value_q,
	output logic      [15:0]        rd_word
);

	// only the value field is stored, so reserved bits cannot echo back
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			value_q <= TRIP_RESET;
		end else if (wr_en) begin
			value_q <= wr_data[TRIP_MSB:TRIP_LSB];
		end
	end

	assign rd_word = {3'h0, value_q, 2'h0};

endmodule
`default_nettype wire

// ===== hdl/tsc_hyst_flag.sv
// tsc_hyst_flag: one signed threshold flag with optional hysteresis band
`timescale 1ns/1ns
`default_nettype none

module tsc_hyst_flag #(
	parameter bit ABOVE = 1'b1
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// evaluation
	input  wire logic        eval,
	input  wire logic [12:0] sample,
	input  wire logic [12:0] limit,
	input  wire logic [13:0] hyst,
	// result
	output logic             flag_q
);

	// one extra bit so limit minus band never wraps
	wire logic signed [13:0] s_x  = $signed({sample[12], sample});
	wire logic signed [13:0] l_x  = $signed({limit[12], limit});
	wire logic signed [13:0] l_lo = l_x - $signed(hyst);

	wire logic set_c = ABOVE ? (s_x > l_x) : (s_x < l_lo);
	wire logic clr_c = ABOVE ? (s_x <= l_lo) : (s_x >= l_x);

	// inside the band the flag keeps its last state
	wire logic flag_d = set_c ? 1'b1 : (clr_c ? 1'b0 : flag_q);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_q <= 1'b0;
		end else if (eval) begin
			flag_q <= flag_d;
		end
	end

endmodule
`default_nettype wire

// ===== hdl/tsc_top.sv
// tsc_top: trip-point registers, reading register and flag logic over ahb-lite
`timescale 1ns/1ns
`default_nettype none

// Contract
// - readings and trip points are two's-complement so negative temperatures compare right
// - upper and lower limits bound the alarm window in 0.25 degree steps
// - reserved trip register bits always read back zero
// - lower limit value in bits 12..2, zeros above, reserved bits below
// - upper limit uses the same layout as the lower limit
// - critical limit uses the same step and layout as the limits
// - reading register is read-only; writes change nothing
// - reading occupies bits 12..0 in 0.0625 degree steps
// - reading bit 12 weighs -256 degrees and is the sign position
// - top three reading register bits report the three threshold comparisons
// - bit 13 set below lower limit minus the hysteresis band, clear at or above lower limit
// - bit 14 set above the window, clear at or below upper limit minus the hysteresis band
// - bit 15 set above critical limit, clear at or below it
// - window flags use hysteresis below the lower and upper limits
// - hysteresis code 00 off, 01 1.5, 10 3, 11 6 degrees
module tsc_top
	import tsc_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,

	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [1:0]       hresp,
	output logic [31:0]      hrdata,

	// conversion result from the sensing core
	input  wire logic        conv_valid,
	input  wire logic [12:0] conv_value,

	// flag outputs toward the event logic
	output logic             below_window,
	output logic             above_window,
	output logic             above_critical
);

	// ************************************************************
	// address phase capture
	// ************************************************************

	// hsize is not checked: only whole-word transfers are issued
	wire logic       addr_take = hsel && hready && htrans[1];
	wire logic [5:0] addr_idx  = haddr[7:2];
	wire logic       addr_hit  = (haddr[31:8] == 24'h000000);

	logic       wr_pend_q;
	logic       rd_pend_q;
	logic [5:0] ph_idx_q;
	logic       ph_hit_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
		end else begin
			wr_pend_q <= addr_take && hwrite;
			rd_pend_q <= addr_take && !hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_idx_q <= 6'h00;
			ph_hit_q <= 1'b0;
		end else if (addr_take) begin
			ph_idx_q <= addr_idx;
			ph_hit_q <= addr_hit;
		end
	end

	// ************************************************************
	// data phase strobes
	// ************************************************************

	// a read takes one wait state so a write just before it is seen
	assign hreadyout = !rd_pend_q;
	assign hresp     = HRESP_OKAY;

	wire logic wr_cfg   = wr_pend_q && ph_hit_q && (ph_idx_q == IDX_CONFIG);
	wire logic wr_upper = wr_pend_q && ph_hit_q && (ph_idx_q == IDX_UPPER);
	wire logic wr_lower = wr_pend_q && ph_hit_q && (ph_idx_q == IDX_LOWER);
	wire logic wr_crit  = wr_pend_q && ph_hit_q && (ph_idx_q == IDX_CRIT);

	// ************************************************************
	// hysteresis setting
	// ************************************************************

	tsc_hyst_t hyst_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hyst_q <= tsc_hyst_t'(HYST_RESET);
		end else if (wr_cfg) begin
			hyst_q <= tsc_hyst_t'(hwdata[HYST_MSB:HYST_LSB]);
		end
	end

	logic [13:0] hyst_dlt;

	always_comb begin
		case (hyst_q)
			TSC_HYST_1P5: hyst_dlt = HYST_DLT_1P5;
			TSC_HYST_3:   hyst_dlt = HYST_DLT_3;
			TSC_HYST_6:   hyst_dlt = HYST_DLT_6;
			default:      hyst_dlt = HYST_DLT_OFF;
		endcase
	end

	wire logic [15:0] cfg_word = {5'h00, hyst_q, 9'h000};

	// ************************************************************
	// trip-point registers: upper, lower, critical
	// ************************************************************

	wire logic [2:0] trip_wr = {wr_crit, wr_lower, wr_upper};

	logic [TRIP_W-1:0] trip_val [3];
	logic [15:0]       trip_rd  [3];

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_trip
			tsc_trip_reg u_trip (
				.hclk    (hclk),
				.hresetn (hresetn),
				.wr_en   (trip_wr[gi]),
				.wr_data (hwdata[15:0]),
				.value_q (trip_val[gi]),
				.rd_word (trip_rd[gi])
			);
		end
	endgenerate

	// trip steps are a quarter degree, the reading a sixteenth:
	// two zero bits below the trip field line the scales up
	wire logic [12:0] lim_upper = {trip_val[0], 2'h0};
	wire logic [12:0] lim_lower = {trip_val[1], 2'h0};
	wire logic [12:0] lim_crit  = {trip_val[2], 2'h0};

	// ************************************************************
	// current reading
	// ************************************************************

	logic [TEMP_W-1:0] reading_q;

	// only the sensing core updates this, never the bus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reading_q <= TEMP_RESET;
		end else if (conv_valid) begin
			reading_q <= conv_value;
		end
	end

	// ************************************************************
	// comparison flags
	// ************************************************************

	logic below_q;
	logic above_q;
	logic crit_q;

	// flags judge the fresh sample so they line up with reading_q
	tsc_hyst_flag #(
		.ABOVE (1'b0)
	) u_below (
		.hclk    (hclk),
		.hresetn (hresetn),
		.eval    (conv_valid),
		.sample  (conv_value),
		.limit   (lim_lower),
		.hyst    (hyst_dlt),
		.flag_q  (below_q)
	);

	tsc_hyst_flag #(
		.ABOVE (1'b1)
	) u_above (
		.hclk    (hclk),
		.hresetn (hresetn),
		.eval    (conv_valid),
		.sample  (conv_value),
		.limit   (lim_upper),
		.hyst    (hyst_dlt),
		.flag_q  (above_q)
	);

	// the critical flag has no band: equal reads as not above
	tsc_hyst_flag #(
		.ABOVE (1'b1)
	) u_crit (
		.hclk    (hclk),
		.hresetn (hresetn),
		.eval    (conv_valid),
		.sample  (conv_value),
		.limit   (lim_crit),
		.hyst    (HYST_DLT_OFF),
		.flag_q  (crit_q)
	);

	assign below_window   = below_q;
	assign above_window   = above_q;
	assign above_critical = crit_q;

	// ************************************************************
	// reading register image
	// ************************************************************

	logic [15:0] temp_word;

	always_comb begin
		temp_word                         = {3'h0, reading_q};
		temp_word[FLAG_BELOW]             = below_q;
		temp_word[FLAG_ABOVE]             = above_q;
		temp_word[FLAG_CRIT]              = crit_q;
	end

	// ************************************************************
	// read multiplexer
	// ************************************************************

	wire logic sel_cfg   = ph_hit_q && (ph_idx_q == IDX_CONFIG);
	wire logic sel_upper = ph_hit_q && (ph_idx_q == IDX_UPPER);
	wire logic sel_lower = ph_hit_q && (ph_idx_q == IDX_LOWER);
	wire logic sel_crit  = ph_hit_q && (ph_idx_q == IDX_CRIT);
	wire logic sel_temp  = ph_hit_q && (ph_idx_q == IDX_TEMP);

	// unmapped words read as zero with an okay answer
	wire logic [15:0] rd_mux =
		sel_cfg   ? cfg_word   :
		sel_upper ? trip_rd[0] :
		sel_lower ? trip_rd[1] :
		sel_crit  ? trip_rd[2] :
		sel_temp  ? temp_word  :
		16'h0000;

	logic [31:0] hrdata_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h00000000;
		end else if (rd_pend_q) begin
			hrdata_q <= {16'h0000, rd_mux};
		end
	end

	assign hrdata = hrdata_q;

endmodule
`default_nettype wire

// ===== verif/tsc_chk.sv
// tsc_chk: bus and flag timing checks of the top module's ports
`timescale 1ns/1ns
`default_nettype none
module tsc_chk (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// bus
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [1:0]  hresp,
	input wire logic [31:0] hrdata,
	// conversion and flags
	input wire logic        conv_valid,
	input wire logic        below_window,
	input wire logic        above_window,
	input wire logic        above_critical
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rd_taken;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence wr_taken;
		hsel && hready && htrans[1] && hwrite;
	endsequence
	sequence rd_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	chk_resp_okay: assert property (hresp == 2'h0) else $error("bad hresp");
	chk_read_wait: assert property (rd_taken |=> rd_wait) else $error("read wait");
	chk_write_nowait: assert property (wr_taken |=> hreadyout) else $error("write wait");
	chk_wait_cause: assert property (
		!hreadyout |-> $past(hsel && htrans[1] && !hwrite)) else $error("stray wait");
	chk_rdata_upper: assert property (hrdata[31:16] == 16'h0000) else $error("upper data");
	chk_rdata_hold: assert property (
		!$stable(hrdata) |-> $past(!hreadyout)) else $error("data moved");
	chk_window_hold: assert property (
		!conv_valid |=> $stable({below_window, above_window})) else $error("window flag moved");
	chk_crit_hold: assert property (
		!conv_valid |=> $stable(above_critical)) else $error("critical flag moved");
endmodule
bind tsc_top tsc_chk tsc_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.conv_valid(conv_valid), .below_window(below_window), .above_window(above_window),
	.above_critical(above_critical));
`default_nettype wire

// ===== verif/tsc_ahb_host.sv
// tsc_ahb_host: register bus master standing for the management host
`timescale 1ns/1ns
`default_nettype none
module tsc_ahb_host (
	// clock
	input  wire logic        hclk,
	// bus
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output var logic         hsel,
	output var logic [31:0]  haddr,
	output var logic [1:0]   htrans,
	output var logic         hwrite,
	output var logic [2:0]   hsize,
	output var logic [31:0]  hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// entered right after a rising edge; values are two's-complement words
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
endmodule
`default_nettype wire

// ===== verif/temp_sensor_trip_compare_test.sv
// temp_sensor_trip_compare_test: self-checking bench of the trip comparator
`timescale 1ns/1ns
`default_nettype none
module temp_sensor_trip_compare_test;
	import tsc_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, conv_valid, bw, aw, ac;
	logic [31:0] haddr, hwdata, hrdata, r, s;
	logic [1:0] htrans, hresp;
	logic [2:0] hsize;
	logic [12:0] conv_value;
	int n_errors, compares, lo, hi, cr, h, t, i;
	bit eb, ea, ec;
	tsc_top tsc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv_valid(conv_valid),
		.conv_value(conv_value), .below_window(bw), .above_window(aw), .above_critical(ac));
	tsc_ahb_host tsc_ahb_host_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	function automatic logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(logic [31:0] a, logic [31:0] d);
		tsc_ahb_host_i.xfer(1'b1, a, d, r);
	endtask
	task automatic rd(logic [31:0] a);
		tsc_ahb_host_i.xfer(1'b0, a, 32'h0, r);
	endtask
	// bench view of the flags: window flags keep a band, the critical flag has none
	function automatic void upd();
		if (t < lo * 4 - h) eb = 1;
		else if (t >= lo * 4) eb = 0;
		if (t > hi * 4) ea = 1;
		else if (t <= hi * 4 - h) ea = 0;
		ec = t > cr * 4;
	endfunction
	task automatic conv();
		conv_valid <= 1'b1;
		conv_value <= t[12:0];
		@(posedge hclk);
		conv_valid <= 1'b0;
		upd();
		rd(32'h14);
		chk("reading", r, {16'h0, ec, ea, eb, t[12:0]});
		chk("flags", {bw, aw, ac}, {eb, ea, ec});
	endtask
	task automatic print_verdict();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		n_errors++;
		print_verdict();
	end
	initial begin
		s = 32'h38f25bf9;
		hresetn = 1'b0;
		conv_valid = 1'b0;
		conv_value = 13'h0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// ************************************************************
		// reset values, unmapped places, reserved bits, read-only reading
		// ************************************************************
		for (i = 1; i < 7; i++) begin
			rd(i * 4);
			chk("reset word", r, 32'h0);
		end
		for (i = 2; i < 5; i++) begin
			t = rnd();
			wr(i * 4, t | 32'hffffe003);
			rd(i * 4);
			chk("trip mask", r, t & 32'h1ffc);
		end
		// alias of the now nonzero upper limit outside the low page
		rd(32'h108);
		chk("unmapped", r, 32'h0);
		wr(32'h14, 32'hffff);
		rd(32'h14);
		chk("read only", r, 32'h0);
		$display("test registers done");
		// ************************************************************
		// random readings around random limits, every hysteresis code
		// ************************************************************
		for (i = 0; i < 80; i++) begin
			if (i % 20 == 0) begin
				lo = -int'(rnd() % 64);
				hi = rnd() % 64;
				cr = hi + rnd() % 32;
				h = (i / 20 == 0) ? 0 : (12 << (i / 20));
				wr(32'h04, (i / 20) << 9);
				wr(32'h08, (hi << 2) & 32'h1ffc);
				wr(32'h0c, (lo << 2) & 32'h1ffc);
				wr(32'h10, (cr << 2) & 32'h1ffc);
				rd(32'h04);
				chk("hysteresis", r, (i / 20) << 9);
			end
			case (i % 5)
				0: t = lo * 4 - h;
				1: t = hi * 4;
				2: t = cr * 4;
				default: t = int'(rnd() % 768) - 384;
			endcase
			conv();
		end
		$display("test flags done");
		// ************************************************************
		// reset in mid-run with the above-window and critical flags raised
		// ************************************************************
		t = cr * 4 + 4;
		conv();
		chk("raised", {aw, ac}, 2'h3);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("reset flags", {bw, aw, ac}, 3'h0);
		rd(32'h10);
		chk("reset limit", r, 32'h0);
		rd(32'h14);
		chk("reset reading", r, 32'h0);
		$display("test reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
